// file: core/adcsi_clip_detect.v
`timescale 1ns/10ps
`include "adcsi_map.vh"
module adcsi_clip_detect (
  input wire [11:0] sample_in,
  input wire [1:0] resolution_in,
  output reg clip_out
);
  // Reduced resolutions test only the low bits that the converter produces
  always @* begin
    case (resolution_in)
      `ADCSI_RES_10: clip_out = (sample_in[9:0] == 10'h000) || (sample_in[9:0] == 10'h3ff);
      `ADCSI_RES_8: clip_out = (sample_in[7:0] == 8'h00) || (sample_in[7:0] == 8'hff);
      default: clip_out = (sample_in == 12'h000) || (sample_in == 12'hfff);
    endcase
  end
endmodule // adcsi_clip_detect

// file: core/adcsi_irq.v
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "adcsi_map.vh"
// What this block does
// - Interrupt line high only when a pending flag has its mask bit set.
// - Writing one to a flag bit clears it; firmware clears after reading data.
// - Masked view is flag AND mask for every bit.
// - Force register write of one sets the matching flag.
// - Scan completion of all enabled regular channels sets end-of-scan flag.
// - With pin enable bit 31, drive two-cycle scan-done pulse starting the cycle after last valid.
// - Scan completing while end-of-scan still set raises overrun flag.
// - Non-continuous trigger during a scan sets a clash flag, scan deferred.
// - Separate clash flags for software, external and injection triggers.
// - External clash never set when external trigger is level sensitive.
// - Injection result landing sets injection done flag.
// - Tailgating injection start raises end-of-scan at that moment.
// - Threshold flag evaluated per channel as soon as its result is ready.
// - Per-channel threshold flags, masks and masked view drive the line.
// - Threshold flag for each regular channel plus one for injection.
// - Threshold and clip force registers set flags and read back flags.
// - Raw sample at min or max code sets channel clip flag at once.
// - Reduced resolution tests 10-bit or 8-bit extremes.
// - Per-channel clip masks and masked view drive the line.
// - Summary mirrors masked main flags plus OR of regular threshold and clip.
module adcsi_irq #(
  parameter CHANNELS = 16
) (
  input wire clock_in,
  input wire rst_b_in,
  input wire [3:0] addr_in,
  input wire [31:0] wdata_in,
  input wire wr_in,
  input wire rd_in,
  output reg [31:0] rdata_out,
  input wire scan_done_in,
  input wire last_valid_in,
  input wire tailgate_start_in,
  input wire scan_busy_in,
  input wire sw_trigger_in,
  input wire ext_trigger_in,
  input wire ext_level_mode_in,
  input wire inj_start_in,
  input wire injection_result_register_in,
  input wire chan_result_in,
  input wire [4:0] chan_id_in,
  input wire threshold_hit_in,
  input wire raw_valid_in,
  input wire [4:0] raw_chan_in,
  input wire [11:0] raw_sample_in,
  input wire [1:0] raw_resolution_in,
  output reg irq_out,
  output reg scan_done_pin_out,
  output reg scan_done_pin_oe_out
);
  reg [`ADCSI_MAIN_W-1:0] main_flag;
  reg [`ADCSI_MAIN_W-1:0] main_mask;
  reg [CHANNELS-1:0] thr_flag;
  reg [CHANNELS-1:0] thr_mask;
  reg [CHANNELS-1:0] clip_flag;
  reg [CHANNELS-1:0] clip_mask;
  reg [31:0] sample_ctrl;
  reg [1:0] pin_count;
  reg [`ADCSI_MAIN_W-1:0] next_main_flag;
  reg [CHANNELS-1:0] next_thr_flag;
  reg [CHANNELS-1:0] next_clip_flag;
  reg [`ADCSI_MAIN_W-1:0] main_hw;
  reg [CHANNELS-1:0] thr_hw;
  reg [CHANNELS-1:0] clip_hw;
  reg [31:0] next_rdata;
  reg next_irq;
  wire raw_clip;
  wire inj_chan_result;
  wire inj_raw;
  wire eos_event;
  wire [`ADCSI_MAIN_W-1:0] main_masked;
  wire [CHANNELS-1:0] thr_masked;
  wire [CHANNELS-1:0] clip_masked;
  wire [31:0] summary;

  // One-hot decode of a channel number, zero for the injection slot
  function [CHANNELS-1:0] chan_onehot;
    input [4:0] id;
    integer i;
    begin
      chan_onehot = {CHANNELS{1'b0}};
      for (i = 0; i < CHANNELS; i = i + 1) begin
        if (id == i[4:0]) begin
          chan_onehot[i] = 1'b1;
        end
      end
    end
  endfunction

  // Channel number CHANNELS denotes the injection channel
  function is_inj;
    input [4:0] id;
    begin
      is_inj = (id == CHANNELS[4:0]);
    end
  endfunction

  function [31:0] widen_main;
    input [`ADCSI_MAIN_W-1:0] v;
    begin
      widen_main = {{(32-`ADCSI_MAIN_W){1'b0}}, v};
    end
  endfunction

  function [31:0] widen_chan;
    input [CHANNELS-1:0] v;
    begin
      widen_chan = {{(32-CHANNELS){1'b0}}, v};
    end
  endfunction

  adcsi_clip_detect u_clip (
    .sample_in(raw_sample_in),
    .resolution_in(raw_resolution_in),
    .clip_out(raw_clip)
  );

  assign inj_chan_result = chan_result_in && is_inj(chan_id_in);
  assign inj_raw = raw_valid_in && is_inj(raw_chan_in);
  assign eos_event = scan_done_in || tailgate_start_in;
  assign main_masked = main_flag & main_mask;
  assign thr_masked = thr_flag & thr_mask;
  assign clip_masked = clip_flag & clip_mask;
  assign summary = widen_main(main_masked)
    | ({31'h0000_0000, |thr_masked} << `ADCSI_B_SUM_THR)
    | ({31'h0000_0000, |clip_masked} << `ADCSI_B_SUM_CLIP);

  always @* begin
    main_hw = {`ADCSI_MAIN_W{1'b0}};
    main_hw[`ADCSI_B_EOS] = eos_event;
    main_hw[`ADCSI_B_OVR] = scan_done_in && main_flag[`ADCSI_B_EOS];
    main_hw[`ADCSI_B_SWCL] = sw_trigger_in && scan_busy_in;
    main_hw[`ADCSI_B_EXCL] = ext_trigger_in && scan_busy_in && !ext_level_mode_in;
    main_hw[`ADCSI_B_INJCL] = inj_start_in && scan_busy_in;
    main_hw[`ADCSI_B_INJD] = injection_result_register_in;
    main_hw[`ADCSI_B_INJTH] = inj_chan_result && threshold_hit_in;
    main_hw[`ADCSI_B_INJCLIP] = inj_raw && raw_clip;
    thr_hw = chan_result_in && threshold_hit_in ? chan_onehot(chan_id_in) : {CHANNELS{1'b0}};
    clip_hw = raw_valid_in && raw_clip ? chan_onehot(raw_chan_in) : {CHANNELS{1'b0}};
    next_main_flag = main_flag;
    next_thr_flag = thr_flag;
    next_clip_flag = clip_flag;
    if (wr_in) begin
      case (addr_in)
        `ADCSI_ADDR_FLAG: next_main_flag = main_flag & ~wdata_in[`ADCSI_MAIN_W-1:0];
        `ADCSI_ADDR_FORCE: next_main_flag = main_flag | wdata_in[`ADCSI_MAIN_W-1:0];
        `ADCSI_ADDR_THR_FLAG: next_thr_flag = thr_flag & ~wdata_in[CHANNELS-1:0];
        `ADCSI_ADDR_THR_FORCE: next_thr_flag = thr_flag | wdata_in[CHANNELS-1:0];
        `ADCSI_ADDR_CLIP_FLAG: next_clip_flag = clip_flag & ~wdata_in[CHANNELS-1:0];
        `ADCSI_ADDR_CLIP_FORCE: next_clip_flag = clip_flag | wdata_in[CHANNELS-1:0];
        default: next_main_flag = main_flag;
      endcase
    end
    // Hardware sets are applied last so a same-cycle clear cannot lose an event
    next_main_flag = next_main_flag | main_hw;
    next_thr_flag = next_thr_flag | thr_hw;
    next_clip_flag = next_clip_flag | clip_hw;
    next_irq = (|(next_main_flag & main_mask)) || (|(next_thr_flag & thr_mask))
      || (|(next_clip_flag & clip_mask));
  end

  always @* begin
    case (addr_in)
      `ADCSI_ADDR_FLAG: next_rdata = widen_main(main_flag);
      `ADCSI_ADDR_FORCE: next_rdata = widen_main(main_flag);
      `ADCSI_ADDR_MASK: next_rdata = widen_main(main_mask);
      `ADCSI_ADDR_MASKED: next_rdata = widen_main(main_masked);
      `ADCSI_ADDR_THR_FLAG: next_rdata = widen_chan(thr_flag);
      `ADCSI_ADDR_THR_FORCE: next_rdata = widen_chan(thr_flag);
      `ADCSI_ADDR_THR_MASK: next_rdata = widen_chan(thr_mask);
      `ADCSI_ADDR_THR_MASKED: next_rdata = widen_chan(thr_masked);
      `ADCSI_ADDR_CLIP_FLAG: next_rdata = widen_chan(clip_flag);
      `ADCSI_ADDR_CLIP_FORCE: next_rdata = widen_chan(clip_flag);
      `ADCSI_ADDR_CLIP_MASK: next_rdata = widen_chan(clip_mask);
      `ADCSI_ADDR_CLIP_MASKED: next_rdata = widen_chan(clip_masked);
      `ADCSI_ADDR_SUMMARY: next_rdata = summary;
      `ADCSI_ADDR_SAMPLE_CTRL: next_rdata = sample_ctrl;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      main_flag <= {`ADCSI_MAIN_W{1'b0}};
      main_mask <= {`ADCSI_MAIN_W{1'b0}};
      thr_flag <= {CHANNELS{1'b0}};
      thr_mask <= {CHANNELS{1'b0}};
      clip_flag <= {CHANNELS{1'b0}};
      clip_mask <= {CHANNELS{1'b0}};
      sample_ctrl <= `ADCSI_RST_MASK;
      rdata_out <= 32'h0000_0000;
      irq_out <= 1'b0;
    end else begin
      main_flag <= next_main_flag;
      thr_flag <= next_thr_flag;
      clip_flag <= next_clip_flag;
      irq_out <= next_irq;
      if (wr_in && addr_in == `ADCSI_ADDR_MASK) begin
        main_mask <= wdata_in[`ADCSI_MAIN_W-1:0];
      end
      if (wr_in && addr_in == `ADCSI_ADDR_THR_MASK) begin
        thr_mask <= wdata_in[CHANNELS-1:0];
      end
      if (wr_in && addr_in == `ADCSI_ADDR_CLIP_MASK) begin
        clip_mask <= wdata_in[CHANNELS-1:0];
      end
      if (wr_in && addr_in == `ADCSI_ADDR_SAMPLE_CTRL) begin
        sample_ctrl <= wdata_in;
      end
      // Read data stand for exactly the cycle after the strobe
      if (rd_in) begin
        rdata_out <= next_rdata;
      end else begin
        rdata_out <= 32'h0000_0000;
      end
    end
  end

  // Pin pulse starts the cycle after the last channel's valid strobe and lasts two cycles
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_count <= 2'h0;
      scan_done_pin_out <= 1'b0;
      scan_done_pin_oe_out <= 1'b0;
    end else begin
      // Follow the write itself so the enable never lags the register
      if (wr_in && addr_in == `ADCSI_ADDR_SAMPLE_CTRL) begin
        scan_done_pin_oe_out <= wdata_in[`ADCSI_B_PIN_EN];
      end else begin
        scan_done_pin_oe_out <= sample_ctrl[`ADCSI_B_PIN_EN];
      end
      if (last_valid_in && sample_ctrl[`ADCSI_B_PIN_EN]) begin
        pin_count <= `ADCSI_PIN_PULSE_CYC - 2'h1;
        scan_done_pin_out <= 1'b1;
      end else if (pin_count != 2'h0) begin
        pin_count <= pin_count - 2'h1;
        scan_done_pin_out <= 1'b1;
      end else begin
        scan_done_pin_out <= 1'b0;
      end
    end
  end
endmodule // adcsi_irq

// file: core/adcsi_map.vh
`ifndef ADCSI_MAP_VH
`define ADCSI_MAP_VH
// Register word addresses
`define ADCSI_ADDR_FLAG 4'h0
`define ADCSI_ADDR_FORCE 4'h1
`define ADCSI_ADDR_MASK 4'h2
`define ADCSI_ADDR_MASKED 4'h3
`define ADCSI_ADDR_THR_FLAG 4'h4
`define ADCSI_ADDR_THR_FORCE 4'h5
`define ADCSI_ADDR_THR_MASK 4'h6
`define ADCSI_ADDR_THR_MASKED 4'h7
`define ADCSI_ADDR_CLIP_FLAG 4'h8
`define ADCSI_ADDR_CLIP_FORCE 4'h9
`define ADCSI_ADDR_CLIP_MASK 4'ha
`define ADCSI_ADDR_CLIP_MASKED 4'hb
`define ADCSI_ADDR_SUMMARY 4'hc
`define ADCSI_ADDR_SAMPLE_CTRL 4'hd
// Main flag group bit positions
`define ADCSI_B_EOS 0
`define ADCSI_B_OVR 1
`define ADCSI_B_SWCL 2
`define ADCSI_B_EXCL 3
`define ADCSI_B_INJCL 4
`define ADCSI_B_INJD 5
`define ADCSI_B_INJTH 6
`define ADCSI_B_INJCLIP 7
`define ADCSI_MAIN_W 8
// Summary aggregate bits
`define ADCSI_B_SUM_THR 30
`define ADCSI_B_SUM_CLIP 31
// Sample control pin enable bit
`define ADCSI_B_PIN_EN 31
// Reset values
`define ADCSI_RST_FLAG 32'h0000_0000
`define ADCSI_RST_MASK 32'h0000_0000
// Resolution codes
`define ADCSI_RES_12 2'h0
`define ADCSI_RES_10 2'h1
`define ADCSI_RES_8 2'h2
// Scan done pin pulse length in system clocks
`define ADCSI_PIN_PULSE_CYC 2'h2
`endif

// file: sim/adcsi_host_model.sv
`timescale 1ns/10ps
module adcsi_host_model (
  input wire clock_in,
  input wire rst_b_in,
  input wire irq_in,
  output reg [7:0] taken_out
);
  reg seen;
  // Handler entered once per rising level
  always @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      seen <= 1'b0;
      taken_out <= 8'h00;
    end else begin
      seen <= irq_in;
      if (irq_in && !seen) taken_out <= taken_out + 8'h01;
    end
  end
endmodule // adcsi_host_model

// file: sim/adcsi_irq_sva.sv
`timescale 1ns/10ps
`include "adcsi_map.vh"
module adcsi_irq_chk (
  input wire clock_in,
  input wire rst_b_in,
  input wire [3:0] addr_in,
  input wire [31:0] wdata_in,
  input wire [31:0] rdata_out,
  input wire wr_in,
  input wire rd_in,
  input wire scan_done_in,
  input wire last_valid_in,
  input wire tailgate_start_in,
  input wire sw_trigger_in,
  input wire ext_trigger_in,
  input wire inj_start_in,
  input wire injection_result_register_in,
  input wire chan_result_in,
  input wire raw_valid_in,
  input wire irq_out,
  input wire scan_done_pin_out,
  input wire scan_done_pin_oe_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  // Flags move only on events or writes, so the line is predictable in quiet cycles
  wire quiet = !(scan_done_in | tailgate_start_in | sw_trigger_in | ext_trigger_in |
    inj_start_in | injection_result_register_in | chan_result_in | raw_valid_in);
  property p_pin_pulse;
    last_valid_in && scan_done_pin_oe_out && !wr_in |=> scan_done_pin_out [*2];
  endproperty
  a_pin_pulse: assert property (p_pin_pulse) else $error("pin pulse short");
  property p_pin_cause;
    $rose(scan_done_pin_out) |-> $past(last_valid_in);
  endproperty
  a_pin_cause: assert property (p_pin_cause) else $error("pin without cause");
  property p_pin_len;
    scan_done_pin_out [*3] |-> $past(last_valid_in) || $past(last_valid_in, 2);
  endproperty
  a_pin_len: assert property (p_pin_len) else $error("pin pulse long");
  property p_oe_set;
    wr_in && addr_in == `ADCSI_ADDR_SAMPLE_CTRL |=> scan_done_pin_oe_out == $past(wdata_in[31]);
  endproperty
  a_oe_set: assert property (p_oe_set) else $error("pin enable wrong");
  property p_oe_hold;
    !wr_in |=> $stable(scan_done_pin_oe_out);
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("pin enable moved");
  property p_irq_sum;
    rd_in && addr_in == `ADCSI_ADDR_SUMMARY && quiet |=> irq_out == (rdata_out != 32'h0);
  endproperty
  a_irq_sum: assert property (p_irq_sum) else $error("line and summary differ");
  property p_irq_stable;
    !wr_in && quiet |=> $stable(irq_out);
  endproperty
  a_irq_stable: assert property (p_irq_stable) else $error("line moved alone");
  property p_force_set;
    wr_in && addr_in == `ADCSI_ADDR_FORCE ##1 rd_in && addr_in == `ADCSI_ADDR_FLAG
      |=> (rdata_out[7:0] & $past(wdata_in[7:0], 2)) == $past(wdata_in[7:0], 2);
  endproperty
  a_force_set: assert property (p_force_set) else $error("force lost");
endmodule // adcsi_irq_chk
bind adcsi_irq adcsi_irq_chk chk_u (.*);

// file: sim/adcsi_irq_tb.sv
`timescale 1ns/10ps
`include "adcsi_map.vh"
module adcsi_irq_tb;
  reg clk = 1'b0, rst_b = 1'b0, wen = 1'b0, ren = 1'b0, busy = 1'b0, lvl = 1'b0, hit = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [31:0] wdata = 32'h0;
  reg [8:0] ev = 9'h000;
  reg [4:0] cid = 5'h00, rch = 5'h00;
  reg [11:0] smp = 12'h000;
  reg [1:0] res = 2'h0;
  wire [31:0] rdata;
  wire [7:0] taken;
  wire irq, pin, oe;
  integer n_fail = 0, check_count = 0, cyc = 0, i, j, n;
  adcsi_irq dut_u (.clock_in(clk), .rst_b_in(rst_b), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wen), .rd_in(ren), .rdata_out(rdata), .scan_done_in(ev[0]), .last_valid_in(ev[1]),
    .tailgate_start_in(ev[2]), .scan_busy_in(busy), .sw_trigger_in(ev[3]),
    .ext_trigger_in(ev[4]), .ext_level_mode_in(lvl), .inj_start_in(ev[5]),
    .injection_result_register_in(ev[6]), .chan_result_in(ev[7]), .chan_id_in(cid), .threshold_hit_in(hit),
    .raw_valid_in(ev[8]), .raw_chan_in(rch), .raw_sample_in(smp), .raw_resolution_in(res),
    .irq_out(irq), .scan_done_pin_out(pin), .scan_done_pin_oe_out(oe));
  adcsi_host_model host_u (.clock_in(clk), .rst_b_in(rst_b), .irq_in(irq), .taken_out(taken));
  initial begin
    forever #2 clk = ~clk;
  end
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      n_fail = n_fail + 1;
      complete_run;
    end
  end
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // Tasks start at a rising edge; wr and pulse leave strobes for the next task to set, rd drops ren itself
  task wr(input [3:0] a, input [31:0] d, input [8:0] m = 9'h000);
    begin
      wen <= 1'b1;
      ren <= 1'b0;
      addr <= a;
      wdata <= d;
      ev <= m;
      @(posedge clk);
    end
  endtask
  task rd(input [3:0] a, input [31:0] e);
    begin
      wen <= 1'b0;
      ren <= 1'b1;
      addr <= a;
      ev <= 9'h000;
      @(posedge clk);
      ren <= 1'b0;
      @(negedge clk);
      chk($sformatf("reg %h", a), e, rdata);
      @(posedge clk);
    end
  endtask
  task pulse(input [8:0] m);
    begin
      wen <= 1'b0;
      ren <= 1'b0;
      ev <= m;
      @(posedge clk);
    end
  endtask
  // Quiet the bus and stop mid-cycle where outputs are settled
  task settle;
    begin
      wen <= 1'b0;
      ren <= 1'b0;
      ev <= 9'h000;
      @(negedge clk);
    end
  endtask
  task raw(input [4:0] c, input [11:0] s, input [1:0] r);
    begin
      rch <= c;
      smp <= s;
      res <= r;
      pulse(9'h100);
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(`ADCSI_ADDR_MASK, `ADCSI_RST_MASK);
    rd(4'hf, 32'h0);
    $display("reset test done");
    wr(`ADCSI_ADDR_MASK, 32'h0f);
    wr(`ADCSI_ADDR_FORCE, 32'hff);
    rd(`ADCSI_ADDR_FLAG, 32'hff);
    rd(`ADCSI_ADDR_FORCE, 32'hff);
    rd(`ADCSI_ADDR_MASKED, 32'h0f);
    settle;
    chk("irq", 1, irq);
    @(posedge clk);
    wr(`ADCSI_ADDR_FLAG, 32'h0f);
    rd(`ADCSI_ADDR_FLAG, 32'hf0);
    settle;
    chk("irq", 0, irq);
    @(posedge clk);
    wr(`ADCSI_ADDR_MASK, 32'h0);
    wr(`ADCSI_ADDR_FLAG, 32'hff);
    $display("mask test done");
    pulse(9'h001);
    rd(`ADCSI_ADDR_FLAG, 32'h01);
    pulse(9'h001);
    rd(`ADCSI_ADDR_FLAG, 32'h03);
    wr(`ADCSI_ADDR_FLAG, 32'h03);
    pulse(9'h004);
    rd(`ADCSI_ADDR_FLAG, 32'h01);
    wr(`ADCSI_ADDR_FLAG, 32'h01);
    wr(`ADCSI_ADDR_FLAG, 32'h01, 9'h001);
    rd(`ADCSI_ADDR_FLAG, 32'h01);
    busy <= 1'b1;
    lvl <= 1'b1;
    pulse(9'h018);
    rd(`ADCSI_ADDR_FLAG, 32'h05);
    lvl <= 1'b0;
    pulse(9'h030);
    rd(`ADCSI_ADDR_FLAG, 32'h1d);
    busy <= 1'b0;
    pulse(9'h048);
    rd(`ADCSI_ADDR_FLAG, 32'h3d);
    wr(`ADCSI_ADDR_FLAG, 32'hff);
    $display("event test done");
    hit <= 1'b1;
    cid <= 5'h03;
    pulse(9'h080);
    cid <= 5'h10;
    pulse(9'h080);
    hit <= 1'b0;
    cid <= 5'h04;
    pulse(9'h080);
    raw(5'h05, 12'hfff, 2'h0);
    raw(5'h07, 12'h000, 2'h1);
    raw(5'h09, 12'h000, 2'h2);
    raw(5'h02, 12'h3ff, 2'h0);
    raw(5'h10, 12'h000, 2'h0);
    wr(`ADCSI_ADDR_THR_FORCE, 32'h1);
    rd(`ADCSI_ADDR_THR_FORCE, 32'h9);
    rd(`ADCSI_ADDR_CLIP_FLAG, 32'h2a0);
    rd(`ADCSI_ADDR_FLAG, 32'hc0);
    wr(`ADCSI_ADDR_MASK, 32'hc0);
    wr(`ADCSI_ADDR_THR_MASK, 32'h8);
    wr(`ADCSI_ADDR_CLIP_MASK, 32'h20);
    rd(`ADCSI_ADDR_THR_MASKED, 32'h8);
    rd(`ADCSI_ADDR_CLIP_MASKED, 32'h20);
    rd(`ADCSI_ADDR_SUMMARY, 32'hc00000c0);
    settle;
    chk("host", 2, taken);
    @(posedge clk);
    wr(`ADCSI_ADDR_FLAG, 32'hff);
    wr(`ADCSI_ADDR_THR_FLAG, 32'hffff);
    wr(`ADCSI_ADDR_CLIP_FLAG, 32'hffff);
    rd(`ADCSI_ADDR_SUMMARY, 32'h0);
    $display("channel test done");
    for (j = 0; j < 3; j = j + 1) begin
      n = 1 + (j == 1);
      wr(`ADCSI_ADDR_SAMPLE_CTRL, {j != 2, 31'h0});
      for (i = 0; i < n; i = i + 1) begin
        pulse(9'h002);
      end
      settle;
      chk("oe", j != 2, oe);
      // A second strobe restarts the count, so two cycles remain after it
      for (i = 0; i < 4; i = i + 1) begin
        chk("pin", (j < 2) && (i < 2), pin);
        @(negedge clk);
      end
      @(posedge clk);
    end
    $display("pin test done");
    complete_run;
  end
endmodule // adcsi_irq_tb
